// [hub_strap_defs.vh]
// constants for the hub reset sequencer and strap logic
`ifndef HUB_STRAP_DEFS_VH
`define HUB_STRAP_DEFS_VH

// clock and sequence times
`define CLK_PERIOD_NS 5
`define POR_DELAY_NS 40000
`define STRAP_WINDOW_NS 21000
`define PIN_TURN_NS 50000000
`define TIMER_W 24

// register byte addresses
`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_POWER 8'h04
`define ADDR_LED_SEL 8'h08
`define ADDR_STATUS 8'h0c

// control register fields
`define CTRL_LED_MANUAL 0
`define CTRL_RESET 1'h0
`define POWER_RESET 4'h0
`define LED_SEL_RESET 8'hff

// status register fields
`define ST_GANG 0
`define ST_SELF 1
`define ST_ACTIVE_HIGH 2
`define ST_STRAPS_VALID 3
`define ST_PIN_OUTPUT 4
`define ST_OC_LSB 8
`define ST_OC_MSB 11
`define ST_PWR_LSB 12
`define ST_PWR_MSB 15
`define ST_STATE_LSB 16
`define ST_STATE_MSB 18

// port indicator selector codes, two bits per port
`define LED_SEL_W 2
`define LED_AUTO 2'h0
`define LED_AMBER 2'h1
`define LED_GREEN 2'h2
`define LED_OFF 2'h3

// port pin enable masks
`define PORTS_ALL_OFF 4'hf
`define PORTS_ALL_ON 4'h0
`define PORTS_GANG_OE_N 4'he

`endif

// [seq_delay_timer.v]
// run-gated delay timer, done holds until run drops
`timescale 1ns/1ps

module seq_delay_timer #(
	parameter COUNT = 1
) (
	// clock and reset
	input wire clock,
	input wire reset,
	// control
	input wire run,
	output reg done
);

`include "hub_strap_defs.vh"

	localparam [31:0] LAST_FULL = COUNT - 1;
	localparam [`TIMER_W-1:0] LAST = LAST_FULL[`TIMER_W-1:0];

	reg [`TIMER_W-1:0] count_q;

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			count_q <= {`TIMER_W{1'b0}};
			done <= 1'b0;
		end else if (!run) begin
			count_q <= {`TIMER_W{1'b0}};
			done <= 1'b0;
		end else if (!done) begin
			count_q <= count_q + 1'b1;
			done <= (count_q == LAST);
		end
	end

endmodule

// [led_indicator_channel.v]
// one port indicator: manual or automatic colour, blanked in suspend
`timescale 1ns/1ps

module led_indicator_channel (
	// clock and reset
	input wire clock,
	input wire reset,
	// mode and state
	input wire enable,
	input wire manualMode,
	input wire [1:0] select,
	input wire powered,
	input wire overcurrent,
	input wire suspended,
	// lamps
	output reg amberOn,
	output reg greenOn
);

`include "hub_strap_defs.vh"

	reg amberD;
	reg greenD;

	always @* begin
		amberD = 1'b0;
		greenD = 1'b0;
		if (manualMode) begin
			case (select)
				`LED_AMBER: amberD = 1'b1;
				`LED_GREEN: greenD = 1'b1;
				default: ;
			endcase
		end else begin
			amberD = overcurrent;
			greenD = powered & ~overcurrent;
		end
		if (!enable || suspended) begin
			amberD = 1'b0;
			greenD = 1'b0;
		end
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			amberOn <= 1'b0;
			greenOn <= 1'b0;
		end else begin
			amberOn <= amberD;
			greenOn <= greenD;
		end
	end

endmodule

// [hub_strap_reset_control.v]
// reset sequencing, strap capture, shared suspend pin, port power and indicators
// Operation
// [R1] External reset low or supply not good puts the chip into power-on reset.
// [R2] Core supply monitor fault forces a full internal reset.
// [R3] Internal reset releases about 40 us after power is good.
// [R4] Shared gang pin stays input; port power mode latched within 21 us.
// [R5] About 50 ms after the latch, the shared pin becomes an output.
// [R6] In output mode the shared pin flags global suspend.
// [R7] Strap low means individual power, high means gang power.
// [R8] Self-power strap selects bus-powered or self-powered hub.
// [R9] Port indicators offer manual and automatic control.
// [R10] All indicators go dark during global suspend.
// [R11] Port-2 amber strap 0 selects active-low power enables.
// [R12] Port-2 amber strap 1 selects active-high power enables.
// [R13] Self-power strap 0 is bus-powered, 1 is self-powered.
// [R14] Gang mode uses only port-1 enable and port-1 overcurrent.
// [R15] External reset held low keeps the whole chip in reset.
// [R16] Strap values hold until the next reset and resample only then.
`timescale 1ns/1ps
`include "hub_strap_defs.vh"

module hub_strap_reset_control #(
	parameter POR_CYCLES = (`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	// latch edge lands one cycle after the timer ends, still inside the window
	parameter STRAP_CYCLES = `STRAP_WINDOW_NS / `CLK_PERIOD_NS - 1,
	parameter TURN_CYCLES = (`PIN_TURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire clock,
	input wire reset,
	// reset sources
	input wire extReset_n,
	input wire coreSupplyGood,
	output reg coreReset,
	// straps and shared pins
	input wire selfPowerStrap,
	input wire gangStrapSuspendPinIn,
	output reg gangStrapSuspendPinOut,
	output reg gangStrapSuspendPinOe_n,
	input wire port2AmberIndicatorPinIn,
	// hub state
	input wire globalSuspend,
	output wire selfPowered,
	output wire gangMode,
	// port power
	input wire [3:0] portOvercurrent_n,
	output reg [3:0] portPowerEnable_n,
	output reg [3:0] portPowerEnableOe_n,
	// indicators
	output wire [3:0] amberLedOut,
	output reg [3:0] amberLedOe_n,
	output wire [3:0] greenLedOut,
	output reg [3:0] greenLedOe_n,
	// register port
	input wire [`ADDR_W-1:0] regAddr,
	input wire [31:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regReadData
);

	localparam ST_HOLD = 3'h0;
	localparam ST_POR_WAIT = 3'h1;
	localparam ST_STRAP = 3'h2;
	localparam ST_INPUT = 3'h3;
	localparam ST_RUN = 3'h4;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg gang_q;
	reg self_q;
	reg activeHigh_q;
	reg strapsValid_q;
	reg ledManual_q;
	reg [3:0] powerReq_q;
	reg [7:0] ledSel_q;
	wire porHold;
	wire porDone;
	wire strapDone;
	wire turnDone;
	wire [3:0] ocEff;
	wire [3:0] powerReqEff;
	wire [3:0] powerOn;
	wire pinOutputMode;
	wire [31:0] statusWord;

	// power-on reset sources
	assign porHold = ~extReset_n | ~coreSupplyGood; // [R1] [R2] [R15]

	always @* begin
		state_d = state_q;
		if (porHold) begin
			state_d = ST_HOLD; // [R1] [R15]
		end else begin
			case (state_q)
				ST_HOLD: state_d = ST_POR_WAIT;
				ST_POR_WAIT: if (porDone) state_d = ST_STRAP; // [R3]
				ST_STRAP: if (strapDone) state_d = ST_INPUT; // [R4]
				ST_INPUT: if (turnDone) state_d = ST_RUN; // [R5]
				ST_RUN: state_d = ST_RUN;
				default: state_d = ST_HOLD;
			endcase
		end
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= ST_HOLD;
			coreReset <= 1'b1;
		end else begin
			state_q <= state_d;
			coreReset <= (state_d == ST_HOLD) || (state_d == ST_POR_WAIT); // [R3]
		end
	end

	seq_delay_timer #(.COUNT(POR_CYCLES)) porTimer (
		.clock(clock),
		.reset(reset),
		.run(state_q == ST_POR_WAIT),
		.done(porDone)
	);

	seq_delay_timer #(.COUNT(STRAP_CYCLES)) strapTimer (
		.clock(clock),
		.reset(reset),
		.run(state_q == ST_STRAP),
		.done(strapDone)
	);

	seq_delay_timer #(.COUNT(TURN_CYCLES)) turnTimer (
		.clock(clock),
		.reset(reset),
		.run(state_q == ST_INPUT),
		.done(turnDone)
	);

	// strap capture, held until the next reset
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			gang_q <= 1'b0;
			self_q <= 1'b0;
			activeHigh_q <= 1'b0;
			strapsValid_q <= 1'b0;
		end else if (porHold) begin
			gang_q <= 1'b0; // [R16]
			self_q <= 1'b0;
			activeHigh_q <= 1'b0;
			strapsValid_q <= 1'b0;
		end else if (state_q == ST_STRAP && strapDone) begin
			gang_q <= gangStrapSuspendPinIn; // [R4] [R7]
			self_q <= selfPowerStrap; // [R8] [R13]
			activeHigh_q <= port2AmberIndicatorPinIn; // [R11] [R12]
			strapsValid_q <= 1'b1;
		end
	end

	assign selfPowered = self_q; // [R8]
	assign gangMode = gang_q;
	assign pinOutputMode = (state_q == ST_RUN);

	// shared gang pin: input until the turn, then suspend flag
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			gangStrapSuspendPinOut <= 1'b0;
			gangStrapSuspendPinOe_n <= 1'b1;
		end else begin
			gangStrapSuspendPinOe_n <= ~pinOutputMode; // [R4] [R5]
			gangStrapSuspendPinOut <= pinOutputMode & globalSuspend; // [R6]
		end
	end

	// port power with overcurrent cut-off
	assign ocEff = gang_q ? {4{~portOvercurrent_n[0]}} : ~portOvercurrent_n; // [R14]
	assign powerReqEff = gang_q ? {4{powerReq_q[0]}} : powerReq_q; // [R14]
	assign powerOn = strapsValid_q ? (powerReqEff & ~ocEff) : `PORTS_ALL_ON;

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			portPowerEnable_n <= `PORTS_ALL_OFF;
			portPowerEnableOe_n <= `PORTS_ALL_OFF;
		end else begin
			portPowerEnable_n <= activeHigh_q ? powerOn : ~powerOn; // [R11] [R12]
			if (!strapsValid_q)
				portPowerEnableOe_n <= `PORTS_ALL_OFF;
			else if (gang_q)
				portPowerEnableOe_n <= `PORTS_GANG_OE_N; // [R14]
			else
				portPowerEnableOe_n <= `PORTS_ALL_ON;
		end
	end

	// indicators, pins released until straps are in
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : ledPort
			led_indicator_channel channel (
				.clock(clock),
				.reset(reset),
				.enable(strapsValid_q),
				.manualMode(ledManual_q), // [R9]
				.select(ledSel_q[i*`LED_SEL_W +: `LED_SEL_W]),
				.powered(powerOn[i]),
				.overcurrent(ocEff[i]),
				.suspended(globalSuspend), // [R10]
				.amberOn(amberLedOut[i]),
				.greenOn(greenLedOut[i])
			);
		end
	endgenerate

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			amberLedOe_n <= `PORTS_ALL_OFF;
			greenLedOe_n <= `PORTS_ALL_OFF;
		end else begin
			amberLedOe_n <= strapsValid_q ? `PORTS_ALL_ON : `PORTS_ALL_OFF; // [R11]
			greenLedOe_n <= strapsValid_q ? `PORTS_ALL_ON : `PORTS_ALL_OFF;
		end
	end

	// software registers, cleared with the chip
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ledManual_q <= `CTRL_RESET;
			powerReq_q <= `POWER_RESET;
			ledSel_q <= `LED_SEL_RESET;
		end else if (coreReset) begin
			ledManual_q <= `CTRL_RESET; // [R15]
			powerReq_q <= `POWER_RESET;
			ledSel_q <= `LED_SEL_RESET;
		end else if (regWrite) begin
			case (regAddr)
				`ADDR_CTRL: ledManual_q <= regWriteData[`CTRL_LED_MANUAL]; // [R9]
				`ADDR_POWER: powerReq_q <= regWriteData[3:0];
				`ADDR_LED_SEL: ledSel_q <= regWriteData[7:0];
				default: ;
			endcase
		end
	end

	assign statusWord = {13'h0000, state_q, powerOn, ocEff, 3'h0, pinOutputMode,
		strapsValid_q, activeHigh_q, self_q, gang_q};

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			regReadData <= 32'h00000000;
		end else if (regRead) begin
			case (regAddr)
				`ADDR_CTRL: regReadData <= {31'h00000000, ledManual_q};
				`ADDR_POWER: regReadData <= {28'h0000000, powerReq_q};
				`ADDR_LED_SEL: regReadData <= {24'h000000, ledSel_q};
				`ADDR_STATUS: regReadData <= statusWord;
				default: regReadData <= 32'h00000000;
			endcase
		end else begin
			regReadData <= 32'h00000000;
		end
	end

endmodule

// [hub_board.sv]
// board model: pull resistors on the two strap pins
`timescale 1ns/1ps
module hub_board (
	// strap levels
	input wire gangPull,
	input wire amberPull,
	// hub side of shared pins
	input wire pinOut,
	input wire pinOe_n,
	input wire amberOut,
	input wire amberOe_n,
	output wire pinIn,
	output wire amberIn
);
	// released pin settles to its pull level
	assign pinIn = pinOe_n ? gangPull : pinOut;
	assign amberIn = amberOe_n ? amberPull : amberOut;
endmodule

// [hub_check_sva.sv]
// assertions on the reset sequencer and strap ports
`timescale 1ns/1ps
module hub_check (
	// clock and reset
	input wire clock,
	input wire reset,
	// watched ports
	input wire extReset_n,
	input wire coreSupplyGood,
	input wire coreReset,
	input wire selfPowerStrap,
	input wire gangStrapSuspendPinIn,
	input wire gangStrapSuspendPinOut,
	input wire gangStrapSuspendPinOe_n,
	input wire globalSuspend,
	input wire selfPowered,
	input wire gangMode,
	input wire [3:0] portPowerEnableOe_n,
	input wire [3:0] amberLedOut,
	input wire [3:0] greenLedOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire ok = extReset_n && coreSupplyGood;
	property p_ext; !extReset_n |=> coreReset; endproperty
	a_ext: assert property (p_ext) else $error("ext reset ignored");
	property p_sup; !coreSupplyGood |=> coreReset; endproperty
	a_sup: assert property (p_sup) else $error("supply fault ignored");
	property p_rel; ok [*8] ##1 ok [*2] |-> !coreReset; endproperty
	a_rel: assert property (p_rel) else $error("reset held too long");
	property p_por; $fell(coreReset) |-> $past(ok, 4); endproperty
	a_por: assert property (p_por) else $error("reset released early");
	property p_hold; $fell(coreReset) |-> gangStrapSuspendPinOe_n [*6]; endproperty
	a_hold: assert property (p_hold) else $error("shared pin driven early");
	property p_flag;
		!gangStrapSuspendPinOe_n && $past(!gangStrapSuspendPinOe_n)
		|-> gangStrapSuspendPinOut == $past(globalSuspend);
	endproperty
	a_flag: assert property (p_flag) else $error("suspend flag wrong");
	property p_dark; globalSuspend [*3] |-> (amberLedOut | greenLedOut) == 4'h0; endproperty
	a_dark: assert property (p_dark) else $error("lamp lit in suspend");
	property p_gang; gangMode && $past(gangMode) |-> portPowerEnableOe_n[3:1] == 3'h7; endproperty
	a_gang: assert property (p_gang) else $error("gang port driven");
	property p_latch; $rose(gangMode) |-> $past(gangStrapSuspendPinIn); endproperty
	a_latch: assert property (p_latch) else $error("gang latch wrong");
	property p_self; $rose(selfPowered) |-> $past(selfPowerStrap); endproperty
	a_self: assert property (p_self) else $error("self latch wrong");
	property p_keep; $fell(gangMode) || $fell(selfPowered) |-> coreReset; endproperty
	a_keep: assert property (p_keep) else $error("strap lost");
	c_turn: cover property ($fell(gangStrapSuspendPinOe_n));
	c_gang: cover property ($rose(gangMode));
	c_flag: cover property (gangStrapSuspendPinOut);
endmodule
bind hub_strap_reset_control hub_check chk (.clock(clock), .reset(reset),
	.extReset_n(extReset_n), .coreSupplyGood(coreSupplyGood), .coreReset(coreReset),
	.selfPowerStrap(selfPowerStrap), .gangStrapSuspendPinIn(gangStrapSuspendPinIn),
	.gangStrapSuspendPinOut(gangStrapSuspendPinOut),
	.gangStrapSuspendPinOe_n(gangStrapSuspendPinOe_n), .globalSuspend(globalSuspend),
	.selfPowered(selfPowered), .gangMode(gangMode),
	.portPowerEnableOe_n(portPowerEnableOe_n), .amberLedOut(amberLedOut),
	.greenLedOut(greenLedOut));

// [testbench.sv]
// random and corner tests of the hub reset and strap control
`timescale 1ns/1ps
`include "hub_strap_defs.vh"
module testbench;
	reg clock, reset, extReset_n, coreSupplyGood, selfPowerStrap, globalSuspend;
	reg gS, aS, regWrite, regRead;
	reg [3:0] oc_n;
	reg [7:0] regAddr;
	reg [31:0] regWriteData, seed, r, st;
	reg [7:0] lamp;
	wire coreReset, gangIn, gangOut, gangOe_n, amberIn, selfPowered, gangMode;
	wire [3:0] pwrEn_n, pwrOe_n, amb, ambOe_n, grn, grnOe_n;
	wire [31:0] regReadData;
	integer num_errors = 0, cmp_count = 0, t, i;
	hub_strap_reset_control #(.POR_CYCLES(4), .STRAP_CYCLES(3), .TURN_CYCLES(5)) DUT (
		.clock(clock), .reset(reset), .extReset_n(extReset_n),
		.coreSupplyGood(coreSupplyGood), .coreReset(coreReset),
		.selfPowerStrap(selfPowerStrap), .gangStrapSuspendPinIn(gangIn),
		.gangStrapSuspendPinOut(gangOut), .gangStrapSuspendPinOe_n(gangOe_n),
		.port2AmberIndicatorPinIn(amberIn), .globalSuspend(globalSuspend),
		.selfPowered(selfPowered), .gangMode(gangMode), .portOvercurrent_n(oc_n),
		.portPowerEnable_n(pwrEn_n), .portPowerEnableOe_n(pwrOe_n), .amberLedOut(amb),
		.amberLedOe_n(ambOe_n), .greenLedOut(grn), .greenLedOe_n(grnOe_n), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData));
	hub_board board (.gangPull(gS), .amberPull(aS), .pinOut(gangOut), .pinOe_n(gangOe_n),
		.amberOut(amb[1]), .amberOe_n(ambOe_n[1]), .pinIn(gangIn), .amberIn(amberIn));
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// {oe_n, pin levels with released pins read as 1}
	function [7:0] expPow(input g, h, input [3:0] p, n);
		reg [3:0] on, oe;
		oe = g ? 4'he : 4'h0;
		on = g ? {3'h0, p[0] & n[0]} : p & n;
		expPow = {oe, (h ? on : ~on) | oe};
	endfunction
	// automatic lamps {green, amber}: amber on overcurrent, green when powered
	function [7:0] expAuto(input g, input [3:0] p, n);
		reg [3:0] oc, on;
		oc = g ? {4{~n[0]}} : ~n;
		on = g ? {4{p[0] & n[0]}} : p & n;
		expAuto = {on, oc};
	endfunction
	function [7:0] expLed(input [7:0] s);
		for (int k = 0; k < 4; k++) begin
			expLed[k] = s[2*k +: 2] == `LED_AMBER;
			expLed[k+4] = s[2*k +: 2] == `LED_GREEN;
		end
	endfunction
	task chk(input string n, input [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1;
		@(posedge clock);
		regWrite <= 0;
	endtask
	task rd(input [7:0] a, output [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1;
		@(posedge clock);
		regRead <= 0;
		#1 d = regReadData;
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		#20000;
		num_errors++;
		end_of_test;
	end
	initial begin
		{reset, extReset_n, coreSupplyGood, selfPowerStrap, globalSuspend} = 5'h1c;
		{gS, aS, regWrite, regRead, oc_n, regAddr, regWriteData} = 0;
		seed = 32'h38091e02;
		repeat (5) @(posedge clock);
		reset <= 0;
		for (t = 0; t < 6; t++) begin
			seed = xs(seed);
			r = seed;
			@(posedge clock);
			gS <= t[0];
			aS <= r[2];
			selfPowerStrap <= r[1];
			oc_n <= r[7:4];
			globalSuspend <= 0;
			if (r[3]) extReset_n <= 0;
			else coreSupplyGood <= 0;
			repeat (2) @(posedge clock);
			#1 chk("inReset", 1, coreReset);
			chk("pinsReleased", 13'h1fff, {pwrOe_n, ambOe_n, grnOe_n, gangOe_n});
			chk("strapsCleared", 0, {gangMode, selfPowered});
			@(posedge clock);
			extReset_n <= 1;
			coreSupplyGood <= 1;
			repeat (3) @(posedge clock);
			#1 chk("porWait", 1, coreReset);
			for (i = 0; i < 20 && coreReset; i++) #5;
			chk("released", 0, coreReset);
			repeat (5) @(posedge clock);
			#1 chk("gang", t[0], gangMode);
			chk("self", r[1], selfPowered);
			chk("pinInput", 1, gangOe_n);
			lamp = expAuto(t[0], 4'h0, r[7:4]);
			@(posedge clock);
			gS <= ~gS;
			rd(`ADDR_STATUS, st);
			chk("polarity", r[2], st[`ST_ACTIVE_HIGH]);
			chk("status", {4'h0, lamp[3:0], 4'h0, 1'b1, r[2], r[1], t[0]}, st[15:0]);
			wr(`ADDR_POWER, r[11:8]);
			repeat (2) @(posedge clock);
			#1 chk("power", expPow(t[0], r[2], r[11:8], r[7:4]), {pwrOe_n, pwrEn_n | pwrOe_n});
			chk("autoLamps", expAuto(t[0], r[11:8], r[7:4]), {grn, amb});
			repeat (4) @(posedge clock);
			#1 chk("pinOutput", 0, gangOe_n);
			chk("strapKept", t[0], gangMode);
			wr(`ADDR_CTRL, 1);
			wr(`ADDR_LED_SEL, r[23:16]);
			repeat (2) @(posedge clock);
			#1 chk("lamps", expLed(r[23:16]), {grn, amb});
			chk("lampsDriven", 0, {ambOe_n, grnOe_n});
			chk("flagIdle", 0, gangOut);
			@(posedge clock);
			globalSuspend <= 1;
			repeat (2) @(posedge clock);
			#1 chk("flag", 1, gangOut);
			chk("dark", 0, {grn, amb});
			rd(8'h10, st);
			chk("unmapped", 0, st);
			$display("test %0d end", t);
		end
		end_of_test;
	end
endmodule
